// *** status_word_pkg.sv ***
package status_word_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned GEN_TIMEOUT_S = 10;
	localparam int unsigned STATIC_TIMEOUT_S = 60;
	localparam logic [31:0] GEN_TIMEOUT_CYCLES = 32'(GEN_TIMEOUT_S * CLK_HZ);
	localparam logic [31:0] STATIC_TIMEOUT_CYCLES = 32'(STATIC_TIMEOUT_S * CLK_HZ);
	localparam logic [15:0] AVG_SHORT_LIMIT_S = 16'h000a;

	// Widths
	localparam int COUNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int IRQ_W = 3;

	// Register byte offsets
	localparam logic [7:0] ADDR_EXT = 8'h00;
	localparam logic [7:0] ADDR_COMPACT = 8'h04;
	localparam logic [7:0] ADDR_OPER = 8'h08;
	localparam logic [7:0] ADDR_ERR = 8'h0c;
	localparam logic [7:0] ADDR_AVG = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// Extended status word fields
	localparam int EXT_GEN = 0;
	localparam int EXT_HCRIT = 1;
	localparam int EXT_HON = 2;
	localparam int EXT_STATIC = 4;
	localparam int EXT_FILL_LSB = 8;
	localparam int EXT_RESTART = 13;

	// Compact status word fields
	localparam int CMP_GEN = 0;
	localparam int CMP_FILL_LSB = 1;
	localparam int CMP_STATIC = 5;
	localparam int CMP_HCRIT = 6;
	localparam int CMP_HON = 7;

	// Protocol operating and error status fields
	localparam int OPS_FILL_LSB = 1;
	localparam int OPS_HCRIT = 5;
	localparam int OPS_HON = 6;
	localparam int ERS_GEN = 0;
	localparam int ERS_STATIC = 1;

	// Interrupt event bits
	localparam int IRQ_GEN = 0;
	localparam int IRQ_STATIC = 1;
	localparam int IRQ_HEAT = 2;

	// Reset values
	localparam logic [31:0] EXT_RESET = 32'h0000_2000;
	localparam logic [15:0] AVG_RESET = 16'h0001;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage

// *** stall_timer_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface stall_timer_if;
	logic run;
	logic expired;
	modport owner (output run, input expired);
	modport timer (input run, output expired);
endinterface

`default_nettype wire

// *** stall_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module stall_timer #(
	parameter logic [31:0] LIMIT = 32'h0000_0010
) (
	input wire logic clk,
	input wire logic rst_b,
	stall_timer_if.timer tif
);
	import status_word_pkg::*;

	typedef struct packed {
		logic [31:0] count;
	} timer_s;

	timer_s q;
	timer_s d;

	// Count while run holds, saturate at the limit, drop to zero when it ends
	always_comb begin
		d = q;
		if (!tif.run) begin
			d.count = 32'h0000_0000;
		end else if (q.count != LIMIT) begin
			d.count = q.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Level decoded from the registered count, so no glitch reaches the status words
	assign tif.expired = (q.count == LIMIT);

	chk_timer_saturate: assert property (@(posedge clk) disable iff (!rst_b)
		(q.count <= LIMIT))
		else $error("stall timer ran past its limit");

endmodule

`default_nettype wire

// *** status_word_builder.sv ***
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Extended word carries 4-bit sixteenths fill code
// - Restart flag bit 13 cleared; reserved bits zero
// - Short averaging: malfunction after ten quiet seconds
// - Long averaging: malfunction under half expected values
// - Compact word bits 1-3: eighths fill code
// - Compact bit 4 zero, bit 5 static
// - Compact bits 6, 7: heating criterion, heating on
// - Operating status bits 0,4,7 zero, fill
// - Operating status bits 5, 6: heating flags
// - Error status: general bit 0, static bit 1
// - Protocol words kept separate from status words
// - Compact word derived from extended word
// - Extended word malfunction, heating and fill layout
module status_word_builder #(
	parameter logic [31:0] GEN_TIMEOUT = status_word_pkg::GEN_TIMEOUT_CYCLES,
	parameter logic [31:0] STATIC_TIMEOUT = status_word_pkg::STATIC_TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [status_word_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [status_word_pkg::COUNT_W-1:0] buffer_count,
	input wire logic heat_criterion,
	input wire logic heat_on,
	input wire logic virtual_temperature_invalid,
	input wire logic telegram_done,
	output logic [31:0] extended_status_word,
	output logic [7:0] compact_status_word,
	output logic [7:0] protocol_operating_status,
	output logic [7:0] protocol_error_status,
	output logic irq
);
	import status_word_pkg::*;

	typedef struct packed {
		logic [31:0] ext;
		logic [7:0] cmp;
		logic [7:0] oper;
		logic [7:0] err;
		logic [15:0] avg;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic restart;
		logic gen;
		logic stat;
		logic hon;
		logic [31:0] rdata;
	} state_s;

	localparam state_s STATE_RESET = '{
		ext: EXT_RESET,
		avg: AVG_RESET,
		irq_mask: IRQ_MASK_RESET,
		restart: 1'b1,
		default: '0
	};

	logic [1:0] rst_pipe_q;
	logic rst_sync_b;
	state_s q;
	state_s d;
	logic [3:0] fill16;
	logic [IRQ_W-1:0] events;

	stall_timer_if gen_tif ();
	stall_timer_if nosample_tif ();
	stall_timer_if vt_tif ();

	// Reset released through two flops so every state and timer flop leaves reset together
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe_q <= 2'b00;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe_q[1];

	// Quiet-time watchdogs restart on every new measured value; the temperature timer restarts once the temperature is valid
	assign gen_tif.run = ~sample_valid;
	assign nosample_tif.run = ~sample_valid;
	assign vt_tif.run = virtual_temperature_invalid;

	stall_timer #(
		.LIMIT(GEN_TIMEOUT)
	) u_gen_timer (
		.clk(clk),
		.rst_b(rst_sync_b),
		.tif(gen_tif)
	);

	stall_timer #(
		.LIMIT(STATIC_TIMEOUT)
	) u_nosample_timer (
		.clk(clk),
		.rst_b(rst_sync_b),
		.tif(nosample_tif)
	);

	stall_timer #(
		.LIMIT(STATIC_TIMEOUT)
	) u_vt_timer (
		.clk(clk),
		.rst_b(rst_sync_b),
		.tif(vt_tif)
	);

	// Sixteenths fill code: highest k with count*16 > k*capacity
	// Capacity is one value per second of averaging time
	always_comb begin
		logic [23:0] scaled;
		logic [23:0] step;
		scaled = {4'h0, buffer_count, 4'h0};
		step = 24'h00_0000;
		fill16 = 4'h0;
		for (int k = 1; k < 16; k++) begin
			step = 24'(k) * {8'h00, q.avg};
			if (q.avg != 16'h0000 && scaled > step) begin
				fill16 = 4'(k);
			end
		end
	end

	// Next state: status words, events, register port
	always_comb begin
		d = q;

		// General malfunction depends on the averaging time
		if (q.avg < AVG_SHORT_LIMIT_S) begin
			d.gen = gen_tif.expired;
		end else begin
			d.gen = ({buffer_count, 1'b0} < {1'b0, q.avg});
		end
		d.stat = nosample_tif.expired | vt_tif.expired;
		d.hon = heat_on;

		// Flag survives until a telegram carrying it has gone out
		d.restart = q.restart & ~telegram_done;

		// Extended word; unlisted bits stay zero
		d.ext = 32'h0000_0000;
		d.ext[EXT_GEN] = d.gen;
		d.ext[EXT_HCRIT] = heat_criterion;
		d.ext[EXT_HON] = heat_on;
		d.ext[EXT_STATIC] = d.stat;
		d.ext[EXT_FILL_LSB +: 4] = fill16;
		d.ext[EXT_RESTART] = d.restart;

		// Compact word taken from the extended word only
		d.cmp = 8'h00;
		d.cmp[CMP_GEN] = d.ext[EXT_GEN];
		d.cmp[CMP_FILL_LSB +: 3] = d.ext[EXT_FILL_LSB + 1 +: 3];
		d.cmp[CMP_STATIC] = d.ext[EXT_STATIC];
		d.cmp[CMP_HCRIT] = d.ext[EXT_HCRIT];
		d.cmp[CMP_HON] = d.ext[EXT_HON];

		// Protocol words, separate from the two above
		d.oper = 8'h00;
		d.oper[OPS_FILL_LSB +: 3] = d.cmp[CMP_FILL_LSB +: 3];
		d.oper[OPS_HCRIT] = d.ext[EXT_HCRIT];
		d.oper[OPS_HON] = d.ext[EXT_HON];
		d.err = 8'h00;
		d.err[ERS_GEN] = d.ext[EXT_GEN];
		d.err[ERS_STATIC] = d.ext[EXT_STATIC];

		// Sticky events; a read clears, but a same-cycle event still lands
		events = '0;
		events[IRQ_GEN] = d.gen & ~q.gen;
		events[IRQ_STATIC] = d.stat & ~q.stat;
		events[IRQ_HEAT] = heat_on & ~q.hon;
		if (reg_rd && reg_addr == ADDR_IRQ_STAT) begin
			d.irq_stat = '0;
		end
		d.irq_stat = d.irq_stat | events;

		// Writes; status words ignore them
		if (reg_wr) begin
			case (reg_addr)
				ADDR_AVG: begin
					d.avg = reg_wdata[15:0];
				end
				ADDR_IRQ_MASK: begin
					d.irq_mask = reg_wdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Read data valid only in the cycle after the strobe
		d.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_EXT: d.rdata = q.ext;
				ADDR_COMPACT: d.rdata = {24'h00_0000, q.cmp};
				ADDR_OPER: d.rdata = {24'h00_0000, q.oper};
				ADDR_ERR: d.rdata = {24'h00_0000, q.err};
				ADDR_AVG: d.rdata = {16'h0000, q.avg};
				ADDR_IRQ_STAT: d.rdata = {29'h0, q.irq_stat};
				ADDR_IRQ_MASK: d.rdata = {29'h0, q.irq_mask};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// Restart sets the flag through the reset value
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from state
	assign extended_status_word = q.ext;
	assign compact_status_word = q.cmp;
	assign protocol_operating_status = q.oper;
	assign protocol_error_status = q.err;
	assign reg_rdata = q.rdata;
	assign irq = |(q.irq_stat & q.irq_mask);

	chk_ext_reserved_zero: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.ext[31:14] == 18'h0 && q.ext[12] == 1'b0 && q.ext[7:5] == 3'h0
		&& q.ext[3] == 1'b0))
		else $error("reserved bit set in extended word");

	chk_restart_cleared: assert property (@(posedge clk) disable iff (!rst_sync_b)
		telegram_done |=> !q.ext[EXT_RESTART] ##1 !q.ext[EXT_RESTART])
		else $error("restart flag not cleared after telegram");

	chk_restart_held: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.restart && !telegram_done) |=> q.ext[EXT_RESTART])
		else $error("restart flag lost without a telegram");

	chk_full_fill_code: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(rst_sync_b && q.avg != 16'h0 && buffer_count >= q.avg && !reg_wr)
		|=> q.ext[EXT_FILL_LSB +: 4] == 4'hf)
		else $error("full buffer not coded as fifteen");

	chk_gen_short: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.avg < AVG_SHORT_LIMIT_S && gen_tif.expired) |=> q.err[ERS_GEN] && q.cmp[CMP_GEN])
		else $error("quiet timeout did not raise malfunction");

	chk_gen_long: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.avg >= AVG_SHORT_LIMIT_S)
		|=> q.ext[EXT_GEN] == ({$past(buffer_count), 1'b0} < {1'b0, $past(q.avg)}))
		else $error("half-buffer malfunction wrong");

	chk_compact_layout: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.cmp[3:1] == q.ext[11:9] && q.cmp[4] == 1'b0 && q.cmp[5] == q.ext[4]
		&& q.cmp[6] == q.ext[1] && q.cmp[7] == q.ext[2] && q.cmp[0] == q.ext[0]))
		else $error("compact word disagrees with extended word");

	chk_oper_layout: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.oper[0] == 1'b0 && q.oper[4] == 1'b0 && q.oper[7] == 1'b0
		&& q.oper[3:1] == q.cmp[3:1]))
		else $error("operating status fill or zero bits wrong");

	chk_oper_heating: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(rst_sync_b && heat_criterion && heat_on)
		|=> q.oper[OPS_HCRIT] && q.oper[OPS_HON] && q.cmp[7])
		else $error("heating flags missing from operating status");

	chk_err_layout: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.err == {6'h00, q.ext[EXT_STATIC], q.ext[EXT_GEN]}))
		else $error("error status layout wrong");

	chk_static_vt: assert property (@(posedge clk) disable iff (!rst_sync_b)
		vt_tif.expired |=> q.cmp[CMP_STATIC] && q.ext[EXT_STATIC])
		else $error("lasting invalid temperature not flagged");

	// A clearing read in the same cycle may drop the level, so it is left out
	chk_irq_on_event: assert property (@(posedge clk) disable iff (!rst_sync_b)
		($rose(q.gen) && q.irq_mask[IRQ_GEN] && !reg_wr
		&& !(reg_rd && reg_addr == ADDR_IRQ_STAT)) |=> irq)
		else $error("unmasked malfunction event gave no interrupt");

	// Under short averaging, an unexpired quiet timer keeps malfunction clear in the next cycle
	chk_gen_short_clear: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(q.avg < AVG_SHORT_LIMIT_S && !gen_tif.expired) |=> !q.ext[EXT_GEN])
		else $error("malfunction raised before the quiet timeout");

	chk_ext_heating: assert property (@(posedge clk) disable iff (!rst_sync_b)
		rst_sync_b |=> q.ext[EXT_HCRIT] == $past(heat_criterion)
		&& q.ext[EXT_HON] == $past(heat_on))
		else $error("heating flags wrong in extended word");

	// Eighths code checked by its own bounds, not through the sixteenths code
	chk_compact_fill_code: assert property (@(posedge clk) disable iff (!rst_sync_b)
		(rst_sync_b && q.avg != 16'h0 && buffer_count != 16'h0)
		|=> ({5'h00, $past(buffer_count), 3'h0} > 24'(q.cmp[3:1]) * {8'h00, $past(q.avg)})
		&& (q.cmp[3:1] == 3'h7
		|| {5'h00, $past(buffer_count), 3'h0}
		<= (24'(q.cmp[3:1]) + 24'h1) * {8'h00, $past(q.avg)}))
		else $error("compact fill code outside its eighth");

	// Read data must fall back to zero when no read was made
	chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_sync_b)
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data stood without a read");

endmodule

`default_nettype wire

// *** host_logger.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host side: ends a telegram on request and keeps the word it carried
module host_logger (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic send,
	input wire logic [31:0] extended_status_word,
	output logic telegram_done,
	output logic [31:0] last_word
);
	// Done follows send one cycle later and lasts as long as send is held
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			telegram_done <= 1'b0;
			last_word <= 32'h0;
		end else begin
			telegram_done <= send;
			if (send) begin
				last_word <= extended_status_word;
			end
		end
	end
endmodule

`default_nettype wire

// *** test_status_word_builder.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_status_word_builder;
	import status_word_pkg::*;
	localparam logic [31:0] GEN_T = 32'h14;
	localparam logic [31:0] ST_T = 32'h32;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, ext, last_word;
	logic sample_valid = 1'b1;
	logic [15:0] buffer_count = 16'h0;
	logic heat_criterion = 1'b0;
	logic heat_on = 1'b0;
	logic vt_bad = 1'b0;
	logic send = 1'b0;
	logic telegram_done, irq;
	logic [7:0] cmp, ops, ers;
	int fail_count = 0;
	int checks_done = 0;

	always #20 clk = ~clk;

	status_word_builder #(.GEN_TIMEOUT(GEN_T), .STATIC_TIMEOUT(ST_T)) u_dut (.clk(clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.buffer_count(buffer_count), .heat_criterion(heat_criterion), .heat_on(heat_on),
		.virtual_temperature_invalid(vt_bad), .telegram_done(telegram_done),
		.extended_status_word(ext), .compact_status_word(cmp),
		.protocol_operating_status(ops), .protocol_error_status(ers), .irq(irq));

	host_logger u_host (.clk(clk), .rst_b(rst_b), .send(send), .extended_status_word(ext),
		.telegram_done(telegram_done), .last_word(last_word));

	task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		expect_eq(reg_rdata, exp, what);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Builds all four words from the conditions and compares them
	task automatic words(input logic [3:0] f, input logic gen, st, hc, ho, rs);
		expect_eq(ext, {18'h0, rs, 1'b0, f, 3'h0, st, 1'b0, ho, hc, gen}, "ext");
		expect_eq({24'h0, cmp}, {24'h0, ho, hc, st, 1'b0, f[3:1], gen}, "cmp");
		expect_eq({24'h0, ops}, {24'h0, 1'b0, ho, hc, 1'b0, f[3:1], 1'b0}, "ops");
		expect_eq({24'h0, ers}, {24'h0, 6'h0, st, gen}, "ers");
	endtask

	task automatic t_reset_restart;
		words(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		rd(ADDR_AVG, 32'h1, "avg reset");
		rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
		rd(8'h40, 32'h0, "unmapped");
		wr(ADDR_EXT, 32'hffff_ffff);
		@(posedge clk);
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		settle(3);
		expect_eq(last_word, 32'h0000_2000, "telegram carried restart");
		words(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test reset_restart done");
	endtask

	// Long averaging, 16 values capacity: every fill code and the half limit
	task automatic t_fill_heat;
		logic [15:0] n;
		wr(ADDR_AVG, 32'h10);
		for (n = 0; n < 18; n++) begin
			@(posedge clk);
			buffer_count <= n;
			heat_criterion <= n[0];
			heat_on <= n[1];
			settle(3);
			words((n == 0) ? 4'h0 : (n > 16) ? 4'hf : 4'(n - 1), n < 8, 1'b0, n[0], n[1], 1'b0);
		end
		// Ten-second average: four values are too few, five are enough
		wr(ADDR_AVG, 32'ha);
		@(posedge clk);
		buffer_count <= 16'h4;
		settle(3);
		words(4'h6, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
		@(posedge clk);
		buffer_count <= 16'h5;
		settle(3);
		words(4'h7, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		$display("test fill_heat done");
	endtask

	task automatic t_irq;
		@(posedge clk);
		heat_on <= 1'b0;
		wr(ADDR_IRQ_MASK, 32'h4);
		rd(ADDR_IRQ_STAT, 32'h5, "drain"); // Malfunction and heating rises so far
		rd(ADDR_IRQ_STAT, 32'h0, "cleared");
		expect_eq({31'h0, irq}, 32'h0, "irq idle");
		@(posedge clk);
		heat_on <= 1'b1;
		settle(3);
		expect_eq({31'h0, irq}, 32'h1, "irq set");
		rd(ADDR_IRQ_STAT, 32'h4, "heat event");
		settle(1);
		expect_eq({31'h0, irq}, 32'h0, "irq clear");
		$display("test irq done");
	endtask

	// Short averaging with no samples, then a persisting bad temperature
	task automatic t_timeouts;
		wr(ADDR_IRQ_MASK, 32'h7);
		wr(ADDR_AVG, 32'h1);
		@(posedge clk);
		heat_on <= 1'b0;
		heat_criterion <= 1'b0;
		buffer_count <= 16'h0;
		sample_valid <= 1'b0;
		settle(15);
		words(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		expect_eq({31'h0, irq}, 32'h0, "irq before timeout");
		settle(11);
		words(4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		expect_eq({31'h0, irq}, 32'h1, "irq on malfunction");
		settle(30);
		words(4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge clk);
		sample_valid <= 1'b1;
		settle(3);
		@(posedge clk);
		vt_bad <= 1'b1;
		settle(56);
		words(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		$display("test timeouts done");
	endtask

	// Restart in mid-run: flag and averaging time come back, then the flag clears again
	task automatic t_second_restart;
		@(posedge clk);
		vt_bad <= 1'b0;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		settle(3);
		words(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		rd(ADDR_AVG, 32'h1, "avg after restart");
		@(posedge clk);
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		settle(3);
		expect_eq(last_word, 32'h0000_2000, "second telegram flag");
		words(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test second_restart done");
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		settle(3);
		t_reset_restart();
		t_fill_heat();
		t_irq();
		t_timeouts();
		t_second_restart();
		conclude();
	end

	// Whole run needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		conclude();
	end
endmodule

`default_nettype wire
